// *** shared/aqt_defs.vh ***
`ifndef AQT_DEFS_VH
`define AQT_DEFS_VH

// Register byte offsets
`define AQT_OFS_CTRL      8'h00
`define AQT_OFS_START     8'h04
`define AQT_OFS_REF       8'h08
`define AQT_OFS_PAUSE     8'h0c
`define AQT_OFS_CLK       8'h10
`define AQT_OFS_SCAN_DIV  8'h14
`define AQT_OFS_SCAN_DLY  8'h18
`define AQT_OFS_CONV_DIV  8'h1c
`define AQT_OFS_CONV_DLY  8'h20
`define AQT_OFS_NCHAN     8'h24
`define AQT_OFS_BUF_SIZE  8'h28
`define AQT_OFS_PRETRIG   8'h2c
`define AQT_OFS_ROUTE     8'h30
`define AQT_OFS_STATUS    8'h34
`define AQT_OFS_COUNT     8'h38
`define AQT_OFS_WR_ADDR   8'h3c

// Control register fields
`define AQT_CTRL_GO       0
`define AQT_CTRL_HALT     1
`define AQT_CTRL_CONT     2
`define AQT_CTRL_REF_EN   3
`define AQT_CTRL_TRIG_EN  4

// Trigger config fields (start, reference, pause)
`define AQT_SRC_LSB       0
`define AQT_SRC_MSB       4
`define AQT_EDGE_FALL     8
`define AQT_PAUSE_EN      9

// Clock config fields
`define AQT_CLK_SCAN_EXT  5
`define AQT_CLK_SCAN_FALL 6
`define AQT_CLK_CONV_LSB  8
`define AQT_CLK_CONV_MSB  12
`define AQT_CLK_CONV_EXT  13
`define AQT_CLK_CONV_FALL 14
`define AQT_CLK_TB_SEL    16
`define AQT_CLK_SINGLE    17

// Route register fields: line code 0..15 function line, 16..23 interboard; pause code 0..7 selects interboard lines
`define AQT_RT_CONV_LSB   0
`define AQT_RT_CONV_EN    5
`define AQT_RT_HOLD_LSB   8
`define AQT_RT_HOLD_EN    13
`define AQT_RT_HOLD_LOW   14
`define AQT_RT_START_LSB  16
`define AQT_RT_START_EN   21
`define AQT_RT_PAUSE_LSB  24
`define AQT_RT_PAUSE_EN   27

// Source index of the analog comparison event
`define AQT_SRC_ANALOG    5'd25

// Reset values
`define AQT_SCAN_DLY_RST  16'h0002
`define AQT_CONV_DLY_RST  16'h0003
`define AQT_NCHAN_RST     8'h01

// Timebase derivation
`define AQT_PCLK_HZ       100000000
`define AQT_TB20_HZ       20000000
`define AQT_TB20_DIV      (`AQT_PCLK_HZ / `AQT_TB20_HZ)

`endif

// *** rtl/aqt_engine.v ***
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`include "aqt_defs.vh"

module aqt_engine #(
   parameter CW = 16,
   parameter SW = 24
) (
   // Clock, reset, enable
   input  wire          pclk,
   input  wire          presetn,
   input  wire          clk_en,
   // APB slave
   input  wire [7:0]    paddr,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   // External lines and analog comparison event
   input  wire [15:0]   func_line_in,
   input  wire [7:0]    ib_line_in,
   input  wire          star_line_in,
   input  wire          analog_cmp_in,
   // Same-clock internal sources
   input  wire [1:0]    counter_out_in,
   input  wire          scan_timebase_tick,
   // Line drivers
   output wire [15:0]   func_line_out,
   output wire [15:0]   func_line_oe,
   output wire [7:0]    ib_line_out,
   output wire [7:0]    ib_line_oe,
   // Converter and sample store
   output reg           adc_convert,
   output reg           buf_wr_stb,
   output reg  [SW-1:0] buf_wr_addr,
   output wire          acq_running
);

   localparam S_IDLE = 3'd0;
   localparam S_WAIT = 3'd1;
   localparam S_PRE  = 3'd2;
   localparam S_ARM  = 3'd3;
   localparam S_POST = 3'd4;
   localparam S_CONT = 3'd5;
   localparam NPIN   = 26;
   localparam integer TB20_DIV_I = `AQT_TB20_DIV;
   localparam [2:0]   TB20_DIV   = TB20_DIV_I[2:0];

   // Pin synchronisers: change taken once stages two and three agree
   wire [NPIN-1:0] pin_raw = {analog_cmp_in, star_line_in,
                              ib_line_in, func_line_in};
   reg  [NPIN-1:0] pin_s1;
   reg  [NPIN-1:0] pin_s2;
   reg  [NPIN-1:0] pin_s3;
   reg  [NPIN-1:0] pin_q;
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1[g] <= 1'b0;
               pin_s2[g] <= 1'b0;
               pin_s3[g] <= 1'b0;
               pin_q[g]  <= 1'b0;
            end else if (clk_en) begin
               pin_s1[g] <= pin_raw[g];
               pin_s2[g] <= pin_s1[g];
               pin_s3[g] <= pin_s2[g];
               if (pin_s2[g] == pin_s3[g])
                  pin_q[g] <= pin_s3[g];
            end
         end
      end
   endgenerate

   // Source vector: 0..15 func, 16..23 interboard, 24 star, 25 analog,
   // 26..27 counters
   wire [31:0] src_vec = {4'h0, counter_out_in, pin_q};

   // Registers
   reg          cont_mode;
   reg          ref_en;
   reg          trig_en;
   reg  [31:0]  start_cfg;
   reg  [31:0]  ref_cfg;
   reg  [31:0]  pause_cfg;
   reg  [31:0]  clk_cfg;
   reg  [CW-1:0] scan_div;
   reg  [CW-1:0] scan_dly;
   reg  [CW-1:0] conv_div;
   reg  [CW-1:0] conv_dly;
   reg  [7:0]   nchan;
   reg  [SW-1:0] buf_size;
   reg  [SW-1:0] pretrig;
   reg  [31:0]  route;

   wire wr_en  = psel & penable & pwrite & clk_en;
   wire cmd_go = wr_en & (paddr == `AQT_OFS_CTRL) & pwdata[`AQT_CTRL_GO];
   wire cmd_halt = wr_en & (paddr == `AQT_OFS_CTRL)
                   & pwdata[`AQT_CTRL_HALT];

   // Engine state
   reg  [2:0]    state;
   reg           in_sample;
   reg  [7:0]    conv_left;
   reg  [CW-1:0] scan_cnt;
   reg  [CW-1:0] conv_cnt;
   reg  [SW-1:0] samp_cnt;
   reg           last_samp;
   reg           scan_int;
   reg  [2:0]    tb20_cnt;
   reg           start_q;
   reg           hold_q;
   reg  [3:0]    prev;

   // Selected sources
   wire start_raw = src_vec[start_cfg[`AQT_SRC_MSB:`AQT_SRC_LSB]];
   wire ref_raw   = src_vec[ref_cfg[`AQT_SRC_MSB:`AQT_SRC_LSB]];
   wire pause_raw = src_vec[pause_cfg[`AQT_SRC_MSB:`AQT_SRC_LSB]];
   wire scan_raw  = src_vec[clk_cfg[`AQT_SRC_MSB:`AQT_SRC_LSB]];
   wire conv_raw  = src_vec[clk_cfg[`AQT_CLK_CONV_MSB:`AQT_CLK_CONV_LSB]];

   wire start_fall = start_cfg[`AQT_EDGE_FALL] &
                     (start_cfg[`AQT_SRC_MSB:`AQT_SRC_LSB] != `AQT_SRC_ANALOG);
   wire start_edge = start_fall ? (prev[0] & ~start_raw)
                                : (~prev[0] & start_raw);
   wire ref_fall = ref_cfg[`AQT_EDGE_FALL] &
                   (ref_cfg[`AQT_SRC_MSB:`AQT_SRC_LSB] != `AQT_SRC_ANALOG);
   wire ref_edge = ref_fall ? (prev[1] & ~ref_raw) : (~prev[1] & ref_raw);
   wire scan_ext_edge = clk_cfg[`AQT_CLK_SCAN_FALL] ?
                        (prev[2] & ~scan_raw) : (~prev[2] & scan_raw);
   wire conv_ext_edge = clk_cfg[`AQT_CLK_CONV_FALL] ?
                        (prev[3] & ~conv_raw) : (~prev[3] & conv_raw);

   wire pause_act = pause_cfg[`AQT_PAUSE_EN] &
                    (pause_raw ^ pause_cfg[`AQT_EDGE_FALL]);

   wire running = (state >= S_PRE);
   wire single  = clk_cfg[`AQT_CLK_SINGLE];
   wire conv_ext = clk_cfg[`AQT_CLK_CONV_EXT] | single;

   // conversion timebase: scan timebase or derived 20 MHz
   wire tb20_tick = (tb20_cnt == 3'd0);
   wire conv_tb = clk_cfg[`AQT_CLK_TB_SEL] ? scan_timebase_tick
                                           : tb20_tick;

   // Mode bits written along with GO must govern that very start,
   // not the stale register contents
   wire cfg_trig = cmd_go ? pwdata[`AQT_CTRL_TRIG_EN] : trig_en;
   wire cfg_cont = cmd_go ? pwdata[`AQT_CTRL_CONT] : cont_mode;
   wire cfg_ref  = cmd_go ? pwdata[`AQT_CTRL_REF_EN] : ref_en;

   // begin on trigger edge, or on the command without triggers
   wire go = ((state == S_IDLE) & cmd_go & ~cfg_trig) |
             ((state == S_WAIT) & start_edge);

   wire scan_ev = single ? conv_ext_edge :
                  clk_cfg[`AQT_CLK_SCAN_EXT] ? scan_ext_edge : scan_int;
   wire int_conv = in_sample & conv_tb & (conv_cnt <= 1);
   wire conv_ev = conv_ext ? conv_ext_edge : int_conv;

   // sample accepted only while running and idle between samples
   wire scan_acc = running & ~in_sample & ~last_samp & scan_ev;
   // conversions only inside an accepted sample
   wire conv_acc = running & conv_ev & (in_sample | (single & scan_acc));
   // conversions per sample from the channel count
   wire [7:0] left_now = scan_acc ? nchan : conv_left;
   wire samp_done = conv_acc & (left_now <= 8'd1);

   wire [SW-1:0] posttrig = buf_size - pretrig;

   assign acq_running = running;
   assign pready = clk_en;
   wire mapped = (paddr[1:0] == 2'b00) & (paddr <= `AQT_OFS_WR_ADDR);
   assign pslverr = psel & penable & ~mapped;

   // APB read data, registered during the setup cycle
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `AQT_OFS_CTRL:     rd_mux = {27'h0, trig_en, ref_en,
                                      cont_mode, 2'b00};
         `AQT_OFS_START:    rd_mux = start_cfg;
         `AQT_OFS_REF:      rd_mux = ref_cfg;
         `AQT_OFS_PAUSE:    rd_mux = pause_cfg;
         `AQT_OFS_CLK:      rd_mux = clk_cfg;
         `AQT_OFS_SCAN_DIV: rd_mux[CW-1:0] = scan_div;
         `AQT_OFS_SCAN_DLY: rd_mux[CW-1:0] = scan_dly;
         `AQT_OFS_CONV_DIV: rd_mux[CW-1:0] = conv_div;
         `AQT_OFS_CONV_DLY: rd_mux[CW-1:0] = conv_dly;
         `AQT_OFS_NCHAN:    rd_mux[7:0] = nchan;
         `AQT_OFS_BUF_SIZE: rd_mux[SW-1:0] = buf_size;
         `AQT_OFS_PRETRIG:  rd_mux[SW-1:0] = pretrig;
         `AQT_OFS_ROUTE:    rd_mux = route;
         `AQT_OFS_STATUS:   rd_mux = {19'h0, conv_left, pause_act,
                                      in_sample, state[2:0]};
         `AQT_OFS_COUNT:    rd_mux[SW-1:0] = samp_cnt;
         `AQT_OFS_WR_ADDR:  rd_mux[SW-1:0] = buf_wr_addr;
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata    <= 32'h0000_0000;
         cont_mode <= 1'b0;
         ref_en    <= 1'b0;
         trig_en   <= 1'b0;
         start_cfg <= 32'h0000_0000;
         ref_cfg   <= 32'h0000_0000;
         pause_cfg <= 32'h0000_0000;
         clk_cfg   <= 32'h0000_0000;
         scan_div  <= {{(CW-1){1'b0}}, 1'b1};
         scan_dly  <= `AQT_SCAN_DLY_RST;
         conv_div  <= {{(CW-1){1'b0}}, 1'b1};
         conv_dly  <= `AQT_CONV_DLY_RST;
         nchan     <= `AQT_NCHAN_RST;
         buf_size  <= {SW{1'b0}};
         pretrig   <= {SW{1'b0}};
         route     <= 32'h0000_0000;
      end else if (clk_en) begin
         if (psel & ~penable & ~pwrite)
            prdata <= rd_mux;
         if (wr_en) begin
            case (paddr)
               `AQT_OFS_CTRL: begin
                  cont_mode <= pwdata[`AQT_CTRL_CONT];
                  ref_en    <= pwdata[`AQT_CTRL_REF_EN];
                  trig_en   <= pwdata[`AQT_CTRL_TRIG_EN];
               end
               `AQT_OFS_START:    start_cfg <= pwdata;
               `AQT_OFS_REF:      ref_cfg <= pwdata;
               `AQT_OFS_PAUSE:    pause_cfg <= pwdata;
               `AQT_OFS_CLK:      clk_cfg <= pwdata;
               `AQT_OFS_SCAN_DIV: scan_div <= pwdata[CW-1:0];
               `AQT_OFS_SCAN_DLY: scan_dly <= pwdata[CW-1:0];
               `AQT_OFS_CONV_DIV: conv_div <= pwdata[CW-1:0];
               `AQT_OFS_CONV_DLY: conv_dly <= pwdata[CW-1:0];
               `AQT_OFS_NCHAN:    nchan <= pwdata[7:0];
               `AQT_OFS_BUF_SIZE: buf_size <= pwdata[SW-1:0];
               `AQT_OFS_PRETRIG:  pretrig <= pwdata[SW-1:0];
               `AQT_OFS_ROUTE:    route <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // Acquisition sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= S_IDLE;
         in_sample   <= 1'b0;
         conv_left   <= 8'h00;
         scan_cnt    <= {CW{1'b0}};
         conv_cnt    <= {CW{1'b0}};
         samp_cnt    <= {SW{1'b0}};
         last_samp   <= 1'b0;
         scan_int    <= 1'b0;
         tb20_cnt    <= 3'd0;
         start_q     <= 1'b0;
         hold_q      <= 1'b0;
         adc_convert <= 1'b0;
         buf_wr_stb  <= 1'b0;
         buf_wr_addr <= {SW{1'b0}};
         prev        <= 4'h0;
      end else if (clk_en) begin
         prev <= {conv_raw, scan_raw, ref_raw, start_raw};
         tb20_cnt <= tb20_tick ? TB20_DIV - 3'd1 : tb20_cnt - 3'd1;
         // one-cycle high pulse at acquisition begin
         start_q <= go;
         adc_convert <= conv_acc;
         hold_q <= conv_acc;
         buf_wr_stb <= samp_done;
         scan_int <= 1'b0;

         // internal sample clock, held while paused
         if (go) begin
            scan_cnt <= scan_dly;
         end else if (running & scan_timebase_tick & ~pause_act) begin
            if (scan_cnt <= 1) begin
               scan_int <= 1'b1;
               scan_cnt <= scan_div;
            end else begin
               scan_cnt <= scan_cnt - 1'b1;
            end
         end

         // conversion counter: delay, then divide per pulse
         if (scan_acc)
            conv_cnt <= conv_dly;
         else if (in_sample & conv_tb) begin
            if (conv_cnt <= 1)
               conv_cnt <= conv_div;
            else
               conv_cnt <= conv_cnt - 1'b1;
         end

         if (conv_acc) begin
            in_sample <= ~samp_done;
            conv_left <= left_now - 8'd1;
         end else if (scan_acc) begin
            in_sample <= 1'b1;
            conv_left <= nchan;
         end

         // store address wraps over the buffer
         if (samp_done) begin
            if (buf_wr_addr + 1'b1 >= buf_size)
               buf_wr_addr <= {SW{1'b0}};
            else
               buf_wr_addr <= buf_wr_addr + 1'b1;
         end

         case (state)
            S_IDLE: begin
               last_samp <= 1'b0;
               if (cmd_go & cfg_trig)
                  state <= S_WAIT;
            end
            S_WAIT: ;
            S_PRE: begin
               if (scan_acc) begin
                  samp_cnt <= samp_cnt - 1'b1;
                  if (samp_cnt <= 1)
                     state <= S_ARM;
               end
            end
            S_ARM: begin
               if (ref_edge) begin
                  samp_cnt <= posttrig;
                  state <= S_POST;
                  if (posttrig == {SW{1'b0}})
                     last_samp <= 1'b1;
               end
            end
            S_POST: begin
               if (scan_acc) begin
                  samp_cnt <= samp_cnt - 1'b1;
                  if (samp_cnt <= 1)
                     last_samp <= 1'b1;
               end
            end
            S_CONT: ;
            default: state <= S_IDLE;
         endcase

         if (go) begin
            buf_wr_addr <= {SW{1'b0}};
            last_samp <= 1'b0;
            if (cfg_cont)
               state <= S_CONT;
            else if (cfg_ref) begin
               samp_cnt <= pretrig;
               state <= (pretrig == {SW{1'b0}}) ? S_ARM : S_PRE;
            end else begin
               samp_cnt <= buf_size;
               state <= S_POST;
            end
         end

         // stop on count done or software command
         if (cmd_halt | (state == S_POST & last_samp &
                         (~in_sample | samp_done))) begin
            state <= S_IDLE;
            in_sample <= 1'b0;
         end
      end
   end

   // Line drivers; outputs registered so lines change on clock edges
   reg [23:0] line_out;
   reg [23:0] line_oe;
   wire hold_lvl = hold_q ^ route[`AQT_RT_HOLD_LOW];
   generate
      for (g = 0; g < 24; g = g + 1) begin : g_line
         wire sel_conv  = route[`AQT_RT_CONV_EN] &
            (route[`AQT_RT_CONV_LSB+4:`AQT_RT_CONV_LSB] == g);
         wire sel_hold  = route[`AQT_RT_HOLD_EN] &
            (route[`AQT_RT_HOLD_LSB+4:`AQT_RT_HOLD_LSB] == g);
         wire sel_start = route[`AQT_RT_START_EN] &
            (route[`AQT_RT_START_LSB+4:`AQT_RT_START_LSB] == g);
         // Pause output may only reach interboard lines
         wire sel_pause = route[`AQT_RT_PAUSE_EN] & (g >= 16) &
            (route[`AQT_RT_PAUSE_LSB+2:`AQT_RT_PAUSE_LSB] == (g & 7));
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               line_out[g] <= 1'b0;
               line_oe[g]  <= 1'b0;
            end else if (clk_en) begin
               line_oe[g] <= sel_conv | sel_hold | sel_start | sel_pause;
               if (sel_conv)
                  line_out[g] <= ~conv_acc;
               else if (sel_hold)
                  line_out[g] <= hold_lvl;
               else if (sel_start)
                  line_out[g] <= go;
               else if (sel_pause)
                  line_out[g] <= pause_act;
               else
                  line_out[g] <= 1'b0;
            end
         end
      end
   endgenerate

   assign func_line_out = line_out[15:0];
   assign func_line_oe  = line_oe[15:0];
   assign ib_line_out   = line_out[23:16];
   assign ib_line_oe    = line_oe[23:16];

endmodule

// *** tb/aqt_assertions.sv ***
`timescale 1ns/1ps
module aqt_assertions (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   input wire        clk_en,
   // Register bus
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Engine outputs
   input wire [15:0] func_line_oe,
   input wire [7:0]  ib_line_oe,
   input wire        adc_convert,
   input wire        buf_wr_stb,
   input wire        acq_running
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ready;
      pready == clk_en;
   endproperty
   a_ready: assert property (p_ready) else $error("pready not clk_en");

   property p_slverr;
      psel && penable |-> pslverr == (paddr > 8'h3c || paddr[1:0] != 2'b00);
   endproperty
   a_slverr: assert property (p_slverr) else $error("bad pslverr");

   // Read data only moves after a read setup cycle
   property p_prdata;
      $changed(prdata) |-> $past(psel && !penable && !pwrite);
   endproperty
   a_prdata: assert property (p_prdata) else $error("prdata moved");

   property p_conv_in_acq;
      adc_convert |-> $past(acq_running);
   endproperty
   a_conv_in_acq: assert property (p_conv_in_acq)
      else $error("conversion outside acquisition");

   property p_stb_conv;
      buf_wr_stb |-> adc_convert;
   endproperty
   a_stb_conv: assert property (p_stb_conv)
      else $error("store strobe without conversion");

   property p_stb_gap;
      buf_wr_stb && clk_en |=> !buf_wr_stb;
   endproperty
   a_stb_gap: assert property (p_stb_gap)
      else $error("samples too close");

   property p_stop;
      $fell(acq_running) |-> buf_wr_stb || $past(buf_wr_stb) ||
         $past(psel && penable && pwrite);
   endproperty
   a_stop: assert property (p_stop) else $error("stop without cause");

   property p_func_oe;
      $changed(func_line_oe) |-> $past(psel && penable && pwrite) ||
         $past(psel && penable && pwrite, 2);
   endproperty
   a_func_oe: assert property (p_func_oe) else $error("func oe moved");

   property p_ib_oe;
      $changed(ib_line_oe) |-> $past(psel && penable && pwrite) ||
         $past(psel && penable && pwrite, 2);
   endproperty
   a_ib_oe: assert property (p_ib_oe) else $error("ib oe moved");
endmodule

bind aqt_engine aqt_assertions i_aqt_assertions (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .func_line_oe(func_line_oe),
   .ib_line_oe(ib_line_oe), .adc_convert(adc_convert),
   .buf_wr_stb(buf_wr_stb), .acq_running(acq_running));

// *** tb/aqt_far_model.sv ***
`timescale 1ns/1ps
module aqt_far_model (
   // Clock and converter strobe
   input  wire         pclk,
   input  wire         adc_convert,
   // Lines toward the engine
   output logic [15:0] func_line_in,
   output logic [7:0]  ib_line_in,
   output logic        star_line_in,
   output logic        analog_cmp_in,
   // Conversions seen by the converter
   output logic [15:0] n_conv
);
   initial begin
      func_line_in = 16'h0000;
      ib_line_in = 8'h00;
      star_line_in = 1'b0;
      analog_cmp_in = 1'b0;
      n_conv = 16'h0000;
   end

   always @(posedge pclk)
      if (adc_convert === 1'b1)
         n_conv <= n_conv + 16'h0001;

   // Level held for gap cycles so it survives the input synchronizer
   task automatic drive(input int b, input logic v, input int gap);
      @(posedge pclk);
      func_line_in[b] <= v;
      repeat (gap) @(posedge pclk);
   endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "aqt_defs.vh"
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        tick = 1'b0;
   logic        ctr = 1'b0;
   logic [7:0]  rnd = 8'h2e;
   logic [31:0] rd;
   logic        err;
   logic [15:0] n_stb = 0, conv_low = 0, hold_hi = 0, start_hi = 0, s, c;
   int          miscompares = 0, n_compared = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, adc_convert, buf_wr_stb, acq_running;
   wire  [23:0] buf_wr_addr;
   wire  [15:0] func_line_in, func_line_out, func_line_oe, n_conv;
   wire  [7:0]  ib_line_in, ib_line_out, ib_line_oe;
   wire         star_line_in, analog_cmp_in;

   aqt_engine #(.CW(16), .SW(24)) i_aqt_engine (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .func_line_in(func_line_in), .ib_line_in(ib_line_in),
      .star_line_in(star_line_in), .analog_cmp_in(analog_cmp_in),
      .counter_out_in({1'b0, ctr}), .scan_timebase_tick(tick),
      .func_line_out(func_line_out), .func_line_oe(func_line_oe),
      .ib_line_out(ib_line_out), .ib_line_oe(ib_line_oe),
      .adc_convert(adc_convert), .buf_wr_stb(buf_wr_stb),
      .buf_wr_addr(buf_wr_addr), .acq_running(acq_running));

   aqt_far_model i_far (
      .pclk(pclk), .adc_convert(adc_convert), .func_line_in(func_line_in),
      .ib_line_in(ib_line_in), .star_line_in(star_line_in),
      .analog_cmp_in(analog_cmp_in), .n_conv(n_conv));

   always #5 pclk = ~pclk;

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   // Samples kept after the reference: buffer size less pretrigger
   function automatic logic [31:0] post_n(input logic [31:0] bsz,
                                          input logic [31:0] pre);
      return bsz - pre;
   endfunction

   always @(posedge pclk) begin
      rnd <= lfsr(rnd);
      tick <= rnd[0];
      n_stb <= n_stb + (buf_wr_stb === 1'b1);
      conv_low <= conv_low + (func_line_oe[2] & !func_line_out[2]);
      hold_hi <= hold_hi + (ib_line_oe[0] & ib_line_out[0]);
      start_hi <= start_hi + (func_line_oe[4] & func_line_out[4]);
   end

   task automatic end_sim;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         miscompares++;
         end_sim;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask

   task automatic waitv(input logic v);
      int k;
      k = 0;
      while (acq_running !== v && k < 100) begin
         @(posedge pclk);
         k++;
      end
      cmp({31'h0, acq_running}, {31'h0, v});
      if (k == 100)
         end_sim;
   endtask

   task automatic pulse(input int b);
      i_far.drive(b, 1'b1, 4 + rnd[2:0]);
      i_far.drive(b, 1'b0, 4 + rnd[3:1]);
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`AQT_OFS_SCAN_DLY, 32'h2);
      rdchk(`AQT_OFS_CONV_DLY, 32'h3);
      rdchk(`AQT_OFS_NCHAN, 32'h1);
      rdchk(8'h40, 32'h0);
      cmp({31'h0, err}, 32'h1);
      // External scan on line 1, conversions on line 0, two channels
      apb(1'b1, `AQT_OFS_CLK, 32'h2021);
      apb(1'b1, `AQT_OFS_NCHAN, 32'h2);
      apb(1'b1, `AQT_OFS_BUF_SIZE, 32'h3);
      apb(1'b1, `AQT_OFS_START, 32'h103);
      apb(1'b1, `AQT_OFS_ROUTE, 32'h243022);
      pulse(1);
      pulse(0);
      cmp(n_conv, 32'h0);
      apb(1'b1, `AQT_OFS_CTRL, 32'h11);
      i_far.drive(3, 1'b1, 6);
      cmp({31'h0, acq_running}, 32'h0);
      i_far.drive(3, 1'b0, 4);
      waitv(1'b1);
      pulse(0);
      for (int i = 0; i < 3; i++) begin
         pulse(1);
         pulse(1);
         pulse(0);
         pulse(0);
         pulse(0);
      end
      cmp(n_conv, 32'h6);
      cmp(n_stb, 32'h3);
      waitv(1'b0);
      cmp(buf_wr_addr, 32'h0);
      cmp(conv_low, 32'h6);
      cmp(func_line_out[2], 32'h1);
      cmp(hold_hi, 32'h6);
      cmp(start_hi, 32'h1);
      // Internal clocks, continuous, paused by a high level on line 0
      apb(1'b1, `AQT_OFS_CLK, 32'h0);
      apb(1'b1, `AQT_OFS_SCAN_DIV, 32'h8);
      apb(1'b1, `AQT_OFS_PAUSE, 32'h200);
      s = n_stb;
      apb(1'b1, `AQT_OFS_CTRL, 32'h5);
      repeat (300) @(posedge pclk);
      cmp(n_stb > s, 32'h1);
      i_far.drive(0, 1'b1, 60);
      s = n_stb;
      repeat (200) @(posedge pclk);
      cmp(n_stb - s, 32'h0);
      i_far.drive(0, 1'b0, 300);
      cmp(n_stb > s, 32'h1);
      apb(1'b1, `AQT_OFS_CTRL, 32'h2);
      waitv(1'b0);
      // One clock on line 0, counter start, reference on line 1
      apb(1'b1, `AQT_OFS_NCHAN, 32'h1);
      apb(1'b1, `AQT_OFS_CLK, 32'h20000);
      apb(1'b1, `AQT_OFS_BUF_SIZE, 32'h5);
      apb(1'b1, `AQT_OFS_PRETRIG, 32'h2);
      apb(1'b1, `AQT_OFS_REF, 32'h1);
      apb(1'b1, `AQT_OFS_START, 32'h1a);
      s = n_stb;
      c = n_conv;
      apb(1'b1, `AQT_OFS_CTRL, 32'h19);
      cmp({31'h0, acq_running}, 32'h0);
      @(posedge pclk) ctr <= 1'b1;
      waitv(1'b1);
      // Early reference is ignored, then two pretrigger and three more
      pulse(1);
      repeat (5) pulse(0);
      pulse(1);
      repeat (3) pulse(0);
      waitv(1'b0);
      cmp(n_stb - s, 5 + post_n(5, 2));
      cmp(n_conv - c, 5 + post_n(5, 2));
      cmp(buf_wr_addr, (5 + post_n(5, 2)) % 5);
      end_sim;
   end
endmodule
